// ==== include/acsp_pkg.sv ====
// Shared constants and types of the serial configuration host.
// Assumes a 125 MHz pclk; the host makes the serial clock itself.
package acsp_pkg;

   // ------------------------------------------------------------
   // Host register map on APB (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam int          APB_AW     = 8;
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_ADDR   = 8'h04;
   localparam logic [7:0]  REG_WDATA  = 8'h08;
   localparam logic [7:0]  REG_RDATA  = 8'h0c;
   localparam logic [7:0]  REG_STATUS = 8'h10;
   localparam logic [7:0]  REG_DIV    = 8'h14;

   // Control fields.
   localparam int          CTRL_START = 0;
   localparam int          CTRL_READ  = 1;
   localparam int          CTRL_GAP   = 3;
   localparam int          CTRL_NB    = 4;
   localparam int          CTRL_W     = 6;

   // Status fields.
   localparam int          STS_BUSY    = 0;
   localparam int          STS_DONE    = 1;
   localparam int          STS_RECOVER = 2;
   localparam int          STS_REFUSED = 3;
   localparam int          STS_LSB     = 4;

   // Half period of the serial clock in pclk cycles.
   localparam logic [7:0]  DIV_RESET = 8'h0a;
   localparam logic [7:0]  DIV_MIN   = 8'h08;

   // ------------------------------------------------------------
   // Device register map seen through the serial link
   // ------------------------------------------------------------
   localparam int          DEV_AW        = 15;
   localparam logic [14:0] DEV_IFCFG     = 15'h0000;
   localparam logic [14:0] DEV_CHSEL     = 15'h0008;
   localparam logic [14:0] DEV_OPEN      = 15'h0013;
   localparam logic [14:0] DEV_OUTFMT    = 15'h0561;
   localparam logic [7:0]  SOFT_RST_VAL  = 8'h81;
   localparam int          IFCFG_LSB_HI  = 6;
   localparam int          IFCFG_LSB_LO  = 1;
   localparam logic [7:0]  CHSEL_MASK    = 8'h03;
   localparam logic [7:0]  OUTFMT_RESET  = 8'h01;

   // ------------------------------------------------------------
   // Framing and timing
   // ------------------------------------------------------------
   localparam int          BYTE_BITS    = 8;
   localparam int          INSTR_BYTES  = 2;
   localparam int          CLK_NS       = 8;
   localparam int          RECOVER_MS   = 5;
   localparam int          RECOVER_CYC  = (RECOVER_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int          GAP_CYC      = 16;

   typedef struct packed
   {
      logic        rw;
      logic        gap;
      logic [1:0]  nb;
      logic [14:0] addr;
      logic [31:0] wdata;
   } acsp_req_t;

   typedef enum logic [2:0]
   {
      S_IDLE    = 3'b000,
      S_SHIFT   = 3'b001,
      S_GAP     = 3'b010,
      S_END     = 3'b011,
      S_RECOVER = 3'b100
   } acsp_state_t;

endpackage

// ==== logic/acsp_sclk_gen.sv ====
// Serial clock divider: toggles sclk each half period while run is high.
// Assumes half is at least two; the clock rests low whenever run is low.
`timescale 1ns/1ps
module acsp_sclk_gen
(
   input  wire logic       pclk,     // system clock
   input  wire logic       presetn,  // asynchronous reset, active low
   input  wire logic       run,      // clock runs while high
   input  wire logic [7:0] half,     // half period in pclk cycles
   output logic            sclk,     // serial clock, registered
   output logic            rise,     // pulse in the cycle sclk goes high
   output logic            fall      // pulse in the cycle sclk goes low
);

   logic [7:0] cnt;
   wire        tick = run && (cnt == half - 8'h01);

   assign rise = tick && !sclk;
   assign fall = tick && sclk;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt  <= 8'h00;
         sclk <= 1'b0;
      end
      else if (!run || tick)
      begin
         cnt  <= 8'h00;
         sclk <= run && !sclk;
      end
      else
         cnt <= cnt + 8'h01;
   end

endmodule

// ==== logic/acsp_host.sv ====
// Host controller for a three-wire converter configuration port, with an APB slave.
// Assumes the device samples data on the rising serial clock and drives on the falling one.
`timescale 1ns/1ps
module acsp_host
#(
   parameter int RECOVER_CYC_P = acsp_pkg::RECOVER_CYC,
   parameter int GAP_CYC_P     = acsp_pkg::GAP_CYC
)
(
   input  wire logic        pclk,          // system clock
   input  wire logic        presetn,       // reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB access phase
   input  wire logic        pwrite,        // APB write
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        quiet_hold,    // converter needs quiet
   output logic             spi_sclk,      // serial clock to the device
   output logic             chip_select_n, // device select, active low
   output logic             sdio_o,        // data line output value
   output logic             sdio_oe,       // data line output enable
   input  wire logic        sdio_i         // data line input
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic [2:0] bit_pos(input logic [2:0] j, input logic lsb);
      bit_pos = lsb ? j : 3'(acsp_pkg::BYTE_BITS - 1) - j;
   endfunction

   function automatic logic instr_bit(input acsp_pkg::acsp_req_t r, input logic [3:0] i,
                                      input logic lsb);
      logic [3:0] k;
      k = i - 4'h1;
      if (i == 4'h0)
         instr_bit = r.rw;
      else if (lsb)
         instr_bit = r.addr[k];
      else
         instr_bit = r.addr[4'he - k];
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   acsp_pkg::acsp_state_t state;
   acsp_pkg::acsp_req_t   req;
   logic [2:0]            bit_idx;
   logic [2:0]            byte_idx;
   logic [31:0]           rx;
   logic [31:0]           wait_cnt;
   logic [14:0]           addr_reg;
   logic [31:0]           wdata_reg;
   logic [7:0]            div_reg;
   logic [acsp_pkg::CTRL_W-1:0] ctrl_reg;
   logic                  done_f;
   logic                  refused_f;
   logic                  lsb_mode;
   logic                  s1;
   logic                  s2;
   logic                  s3;
   logic                  sdio_s;
   logic                  sclk_rise;
   logic                  sclk_fall;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire wr_en    = psel && penable && pwrite;
   wire rd_setup = psel && !penable && !pwrite;
   wire setup    = psel && !penable;
   wire hit_ctrl = (paddr == acsp_pkg::REG_CTRL);
   wire hit_addr = (paddr == acsp_pkg::REG_ADDR);
   wire hit_wdat = (paddr == acsp_pkg::REG_WDATA);
   wire hit_rdat = (paddr == acsp_pkg::REG_RDATA);
   wire hit_sts  = (paddr == acsp_pkg::REG_STATUS);
   wire hit_div  = (paddr == acsp_pkg::REG_DIV);
   wire addr_ok  = hit_ctrl || hit_addr || hit_wdat || hit_rdat || hit_sts || hit_div;

   wire busy     = (state != acsp_pkg::S_IDLE);
   wire recover  = (state == acsp_pkg::S_RECOVER);

   wire [31:0] status_word = {27'h0, lsb_mode, refused_f, recover, done_f, busy};
   wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctrl_reg} :
                        hit_addr ? {17'h0, addr_reg} :
                        hit_wdat ? wdata_reg :
                        hit_rdat ? rx :
                        hit_sts  ? status_word :
                        hit_div  ? {24'h0, div_reg} : 32'h0;

   // ------------------------------------------------------------
   // Start request and its checks
   // ------------------------------------------------------------
   wire        start_req = wr_en && hit_ctrl && pwdata[acsp_pkg::CTRL_START];
   wire        req_read  = pwdata[acsp_pkg::CTRL_READ];
   wire [1:0]  req_nb    = pwdata[acsp_pkg::CTRL_NB +: 2];
   wire [15:0] span_lo   = {1'b0, addr_reg};
   wire [15:0] span_hi   = span_lo + {14'h0000, req_nb};
   wire [15:0] open_loc  = {1'b0, acsp_pkg::DEV_OPEN};
   // The device walks upward through a stream, so a write covers addr to addr + nb.
   wire        open_hit  = !req_read && (span_lo <= open_loc) && (span_hi >= open_loc);
   wire        refuse    = start_req && (busy || quiet_hold || open_hit);
   wire        start_ok  = start_req && !refuse;
   wire        chsel_wr  = !req_read && (addr_reg == acsp_pkg::DEV_CHSEL);
   wire [7:0]  byte0_out = chsel_wr ? (wdata_reg[7:0] & acsp_pkg::CHSEL_MASK)
                                    : wdata_reg[7:0];

   // ------------------------------------------------------------
   // Bit stream
   // ------------------------------------------------------------
   wire       in_data   = (byte_idx >= 3'(acsp_pkg::INSTR_BYTES));
   wire [2:0] last_byte = 3'(req.nb) + 3'(acsp_pkg::INSTR_BYTES);
   wire       last_bit  = (bit_idx == 3'(acsp_pkg::BYTE_BITS - 1));
   wire       last_all  = last_bit && (byte_idx == last_byte);
   wire [1:0] dsel      = 2'(byte_idx - 3'(acsp_pkg::INSTR_BYTES));
   wire [7:0] dbyte     = req.wdata[{dsel, 3'b000} +: 8];
   wire [4:0] rx_idx    = {dsel, bit_pos(bit_idx, lsb_mode)};
   wire       tx_bit    = in_data ? dbyte[bit_pos(bit_idx, lsb_mode)]
                                  : instr_bit(req, {byte_idx[0], bit_idx}, lsb_mode);
   wire       in_shift  = (state == acsp_pkg::S_SHIFT);
   // The host lets go of the line for the data bytes of a readback.
   wire       drive     = in_shift && !(req.rw && in_data);
   wire       capture   = in_shift && sclk_rise && req.rw && in_data;
   wire       srst_frm  = !req.rw && (req.addr == acsp_pkg::DEV_IFCFG) &&
                          (req.wdata[7:0] == acsp_pkg::SOFT_RST_VAL);
   wire       ifcfg_wr  = !req.rw && (req.addr == acsp_pkg::DEV_IFCFG);
   wire       gap_done  = (wait_cnt == 32'(GAP_CYC_P - 1));
   wire       rec_done  = (wait_cnt == 32'(RECOVER_CYC_P - 1));

   acsp_sclk_gen u_sclk
   (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (in_shift),
      .half    (div_reg),
      .sclk    (spi_sclk),
      .rise    (sclk_rise),
      .fall    (sclk_fall)
   );

   // ------------------------------------------------------------
   // Data line input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1     <= 1'b0;
         s2     <= 1'b0;
         s3     <= 1'b0;
         sdio_s <= 1'b0;
      end
      else
      begin
         s1 <= sdio_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            sdio_s <= s3;
      end
   end

   // ------------------------------------------------------------
   // APB registers
   // ------------------------------------------------------------
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata  <= rd_setup ? rd_mux : 32'h0;
         pslverr <= !addr_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_reg  <= 15'h0;
         wdata_reg <= 32'h0;
         div_reg   <= acsp_pkg::DIV_RESET;
         ctrl_reg  <= '0;
      end
      else if (wr_en)
      begin
         if (hit_addr)
            addr_reg <= pwdata[acsp_pkg::DEV_AW-1:0];
         if (hit_wdat)
            wdata_reg <= pwdata;
         if (hit_div)
            div_reg <= (pwdata[7:0] < acsp_pkg::DIV_MIN) ? acsp_pkg::DIV_MIN : pwdata[7:0];
         if (hit_ctrl && !busy)
            ctrl_reg <= pwdata[acsp_pkg::CTRL_W-1:0] &
                        ~(acsp_pkg::CTRL_W'(1) << acsp_pkg::CTRL_START);
      end
   end

   // Sticky flags: a set in the same cycle as a clear wins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_f    <= 1'b0;
         refused_f <= 1'b0;
      end
      else
      begin
         done_f    <= (state == acsp_pkg::S_END) ||
                      (done_f && !(wr_en && hit_sts && pwdata[acsp_pkg::STS_DONE]));
         refused_f <= refuse ||
                      (refused_f && !(wr_en && hit_sts && pwdata[acsp_pkg::STS_REFUSED]));
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state    <= acsp_pkg::S_IDLE;
         req      <= '0;
         bit_idx  <= 3'h0;
         byte_idx <= 3'h0;
         wait_cnt <= 32'h00000000;
         lsb_mode <= 1'b0;
      end
      else
      begin
         case (state)
            acsp_pkg::S_IDLE:
            begin
               if (start_ok)
               begin
                  req.rw    <= req_read;
                  req.gap   <= pwdata[acsp_pkg::CTRL_GAP];
                  req.nb    <= req_nb;
                  req.addr  <= addr_reg;
                  req.wdata <= {wdata_reg[31:8], byte0_out};
                  bit_idx   <= 3'h0;
                  byte_idx  <= 3'h0;
                  state     <= acsp_pkg::S_SHIFT;
               end
            end
            acsp_pkg::S_SHIFT:
            begin
               if (sclk_fall)
               begin
                  if (last_all)
                     state <= acsp_pkg::S_END;
                  else
                  begin
                     bit_idx <= bit_idx + 3'h1;
                     if (last_bit)
                        byte_idx <= byte_idx + 3'h1;
                     if (last_bit && req.gap)
                     begin
                        wait_cnt <= 32'h00000000;
                        state    <= acsp_pkg::S_GAP;
                     end
                  end
               end
            end
            acsp_pkg::S_GAP:
            begin
               wait_cnt <= wait_cnt + 32'h00000001;
               if (gap_done)
                  state <= acsp_pkg::S_SHIFT;
            end
            acsp_pkg::S_END:
            begin
               wait_cnt <= 32'h00000000;
               if (ifcfg_wr)
                  lsb_mode <= req.wdata[acsp_pkg::IFCFG_LSB_HI] |
                              req.wdata[acsp_pkg::IFCFG_LSB_LO];
               if (srst_frm)
                  state <= acsp_pkg::S_RECOVER;
               else
                  state <= acsp_pkg::S_IDLE;
            end
            acsp_pkg::S_RECOVER:
            begin
               // The device reloads its defaults, ordering is back to MSB first.
               lsb_mode <= 1'b0;
               wait_cnt <= wait_cnt + 32'h00000001;
               if (rec_done)
                  state <= acsp_pkg::S_IDLE;
            end
            default:
               state <= acsp_pkg::S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read capture and pin drivers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rx <= 32'h0;
      else if (start_ok && req_read)
         rx <= 32'h0;
      else if (capture)
         rx[rx_idx] <= sdio_s;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chip_select_n <= 1'b1;
         sdio_o        <= 1'b0;
         sdio_oe       <= 1'b0;
      end
      else
      begin
         // Select is low only while bits shift; idle and gaps leave the port floating.
         chip_select_n <= !(in_shift || (state == acsp_pkg::S_IDLE && start_ok));
         sdio_o        <= tx_bit;
         sdio_oe       <= drive;
      end
   end

endmodule

// ==== verification/acsp_host_monitor.sv ====
// Concurrent checks on the ports of acsp_host, attached by bind.
// Assumes frames are spaced by more than GAP_CYC_P + 3 idle pclk cycles.
`timescale 1ns/1ps
module acsp_host_monitor
#(
   parameter int RECOVER_CYC_P = acsp_pkg::RECOVER_CYC,
   parameter int GAP_CYC_P     = acsp_pkg::GAP_CYC
)
(
   input wire logic        pclk,          // clock
   input wire logic        presetn,       // reset, active low
   input wire logic        psel,          // APB select
   input wire logic        penable,       // APB enable
   input wire logic        pwrite,        // APB write
   input wire logic [7:0]  paddr,         // APB address
   input wire logic [31:0] pwdata,        // APB write data
   input wire logic [31:0] prdata,        // APB read data
   input wire logic        pready,        // APB ready
   input wire logic        pslverr,       // APB error
   input wire logic        quiet_hold,    // quiet request
   input wire logic        spi_sclk,      // serial clock
   input wire logic        chip_select_n, // select, active low
   input wire logic        sdio_o,        // data value
   input wire logic        sdio_oe,       // data enable
   input wire logic        sdio_i         // data pin
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Counts rising serial clocks per frame; a long deselect ends the frame.
   int   hi_cnt;
   int   rises;
   logic rwb;
   logic sclk_q;
   wire  frame_over = hi_cnt > GAP_CYC_P + 3;
   wire  sclk_up    = spi_sclk && !sclk_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hi_cnt <= 1000;
         rises  <= 0;
         rwb    <= 1'b0;
         sclk_q <= 1'b0;
      end
      else
      begin
         sclk_q <= spi_sclk;
         hi_cnt <= chip_select_n ? (hi_cnt < 1000 ? hi_cnt + 1 : hi_cnt) : 0;
         rises  <= frame_over ? 0 : rises + (sclk_up ? 1 : 0);
         if (sclk_up && rises == 0)
            rwb <= sdio_o;
      end
   end
   sequence s_sel_fall;
      $fell(chip_select_n);
   endsequence
   sequence s_first_rise;
      !spi_sclk [*2] ##[1:600] $rose(spi_sclk);
   endsequence
   a_sclk_gated: assert property (chip_select_n |-> !spi_sclk)
      else $error("serial clock high while deselected");
   a_frame_start: assert property (s_sel_fall |-> s_first_rise)
      else $error("frame start without a clean first rise");
   a_oe_idle: assert property (chip_select_n [*2] |-> !sdio_oe)
      else $error("data line driven while deselected");
   a_read_turn: assert property (sclk_up && rwb && rises >= 16 |-> !sdio_oe)
      else $error("data line not released for readback");
   a_write_drive: assert property (sclk_up && !(rwb && rises >= 16) |-> sdio_oe)
      else $error("data line not driven at a sampling edge");
   a_byte_count: assert property (hi_cnt == GAP_CYC_P + 3 |->
      rises % 8 == 0 && rises >= 24 && rises <= 48)
      else $error("frame is not whole bytes");
   a_quiet_refuse: assert property ((quiet_hold && frame_over) [*2] |=> chip_select_n)
      else $error("frame started while quiet");
   a_bit_timing: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_o) |->
      !$past(spi_sclk) && $past(spi_sclk, 2))
      else $error("data bit changed away from the falling edge");
endmodule
bind acsp_host acsp_host_monitor #(.RECOVER_CYC_P(RECOVER_CYC_P), .GAP_CYC_P(GAP_CYC_P))
   mon_u (.*);

// ==== verification/acsp_dev_model.sv ====
// Behavioural model of the converter's three-wire configuration port.
// Assumes a pull-up on the data line; pclk times the model's sampling, idle timeout and recovery.
`timescale 1ns/1ps
module acsp_dev_model
#(
   parameter int RCV_P = 200
)
(
   input  wire logic pclk,          // sampling clock
   input  wire logic presetn,       // reset, active low
   input  wire logic sclk,          // serial clock
   input  wire logic chip_select_n, // select, active low
   input  wire logic sdio_o,        // host data value
   input  wire logic sdio_oe,       // host drive enable
   output logic      sdio_i,        // resolved data line
   output logic      early          // frame began during recovery
);
   logic [7:0]  mem [logic [14:0]];
   logic [14:0] addr, ra;
   logic [7:0]  sh;
   logic [7:0]  rb;
   logic        rw, lsb, ps, drv, dbit;
   int          cnt, idle, j, rcv;
   assign sdio_i = sdio_oe ? sdio_o : (drv ? dbit : 1'b1);
   task automatic load_defaults();
      mem.delete();
      mem[acsp_pkg::DEV_CHSEL]  = 8'h03;
      mem[acsp_pkg::DEV_OUTFMT] = acsp_pkg::OUTFMT_RESET;
      lsb = 1'b0;
   endtask
   task automatic store(input logic [14:0] a, input logic [7:0] d);
      if (a == acsp_pkg::DEV_IFCFG && d == acsp_pkg::SOFT_RST_VAL)
      begin
         load_defaults();
         rcv = RCV_P;
      end
      else if (a == acsp_pkg::DEV_IFCFG)
      begin
         mem[a] = d & 8'h7e;
         lsb    = d[acsp_pkg::IFCFG_LSB_HI] | d[acsp_pkg::IFCFG_LSB_LO];
      end
      else
      begin
         if (a != 15'h16 || mem[acsp_pkg::DEV_CHSEL][0])
            mem[a] = d;
         if (a == 15'h16 && mem[acsp_pkg::DEV_CHSEL][1])
            mem[a | 15'h4000] = d;
      end
   endtask
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         load_defaults();
         cnt = 0;
         idle = 0;
         rcv = 0;
         ps = 1'b0;
         early <= 1'b0;
         drv <= 1'b0;
         dbit <= 1'b0;
      end
      else
      begin
         idle = chip_select_n ? idle + 1 : 0;
         if (rcv > 0)
            rcv--;
         if (idle > 12)
            cnt = 0;
         if (chip_select_n)
            drv <= 1'b0;
         else if (sclk && !ps)
         begin
            if (cnt == 0)
            begin
               rw   = sdio_i;
               addr = '0;
               if (rcv > 0)
                  early <= 1'b1;
            end
            else if (cnt < 16)
            begin
               if (lsb)
                  addr[cnt - 1] = sdio_i;
               else
                  addr = {addr[13:0], sdio_i};
            end
            else
            begin
               j = (cnt - 16) % 8;
               sh[lsb ? j : 7 - j] = sdio_i;
               if (j == 7 && !rw)
                  store(addr, sh);
               if (j == 7)
                  addr++;
            end
            cnt++;
         end
         else if (!sclk && rw && cnt >= 16)
         begin
            j = (cnt - 16) % 8;
            ra = (addr == 15'h16 && !mem[acsp_pkg::DEV_CHSEL][0]) ? 15'h4016 : addr;
            rb = mem.exists(ra) ? mem[ra] : 8'h00;
            drv <= 1'b1;
            dbit <= rb[lsb ? j : 7 - j];
         end
         ps = sclk;
      end
   end
endmodule

// ==== verification/tb_acsp_host.sv ====
// Bench for acsp_host: APB master tasks, device model on the serial pins.
// Recovery and gap counts are shortened for the run.
`timescale 1ns/1ps
module tb_acsp_host;
   typedef struct packed
   {
      acsp_pkg::acsp_req_t q;
      logic [31:0]         e;
   } acsp_row_t;
   localparam int        RCV = 200;
   localparam acsp_row_t ROWS [11] = '{
      {2'b00, 2'h0, 15'ha, 32'h5a, 32'h0},
      {2'b10, 2'h0, 15'ha, 32'h0, 32'h5a},
      {2'b10, 2'h0, 15'h561, 32'h0, 32'h1},
      {2'b10, 2'h0, 15'h8, 32'h0, 32'h3},
      {2'b00, 2'h3, 15'h20, 32'h44332211, 32'h0},
      {2'b10, 2'h3, 15'h20, 32'h0, 32'h44332211},
      {2'b01, 2'h1, 15'h30, 32'hbbaa, 32'h0},
      {2'b11, 2'h1, 15'h30, 32'h0, 32'hbbaa},
      {2'b10, 2'h2, 15'h21, 32'h0, 32'h443322},
      {2'b00, 2'h0, 15'h8, 32'hfe, 32'h0},
      {2'b10, 2'h0, 15'h8, 32'h0, 32'h2}};
   logic        pclk, presetn, psel, penable, pwrite, quiet_hold, last_err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, spi_sclk, chip_select_n, sdio_o, sdio_oe, sdio_i, early;
   int          error_cnt, checked, i;
   acsp_host #(.RECOVER_CYC_P(RCV), .GAP_CYC_P(4)) dut_u (.*);
   acsp_dev_model #(.RCV_P(RCV)) model_u
   (
      .pclk(pclk), .presetn(presetn), .sclk(spi_sclk), .chip_select_n(chip_select_n),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdio_i(sdio_i), .early(early)
   );
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         error_cnt++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      apb(1'b0, a, 32'h0, d);
   endtask
   task automatic poll(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         rd(acsp_pkg::REG_STATUS, q);
         n++;
      end
      while (q[b] !== v && n < 3000);
      if (n >= 3000)
      begin
         error_cnt++;
         give_verdict();
      end
   endtask
   task automatic xfer(input acsp_pkg::acsp_req_t r);
      wr(acsp_pkg::REG_ADDR, {17'h0, r.addr});
      wr(acsp_pkg::REG_WDATA, r.wdata);
      wr(acsp_pkg::REG_CTRL, {26'h0, r.nb, r.gap, 1'b0, r.rw, 1'b1});
      poll(acsp_pkg::STS_DONE, 1'b1);
      wr(acsp_pkg::REG_STATUS, 32'h2);
      repeat (16) @(posedge pclk);
   endtask
   task automatic rdev(input logic [14:0] a, input logic [31:0] e);
      xfer({2'b10, 2'h0, a, 32'h0});
      rd(acsp_pkg::REG_RDATA, q);
      chk("rdata", e, q);
   endtask
   task automatic sts(input logic [31:0] e);
      rd(acsp_pkg::REG_STATUS, q);
      chk("status", e, q);
      wr(acsp_pkg::REG_STATUS, e);
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, quiet_hold, paddr, pwdata} = '0;
      {error_cnt, checked} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(acsp_pkg::REG_DIV, q);
      chk("div", {24'h0, acsp_pkg::DIV_RESET}, q);
      rd(acsp_pkg::REG_STATUS, q);
      chk("status", 32'h0, q);
      rd(8'h18, q);
      chk("pslverr", 32'h1, {31'h0, last_err});
      wr(acsp_pkg::REG_DIV, 32'h2);
      rd(acsp_pkg::REG_DIV, q);
      chk("div", {24'h0, acsp_pkg::DIV_MIN}, q);
      wr(acsp_pkg::REG_DIV, 32'h0a);
      for (i = 0; i < 11; i++)
      begin
         xfer(ROWS[i].q);
         rd(acsp_pkg::REG_RDATA, q);
         if (ROWS[i].q.rw)
            chk("rdata", ROWS[i].e, q);
      end
      quiet_hold <= 1'b1;
      wr(acsp_pkg::REG_CTRL, 32'h3);
      sts(32'h8);
      quiet_hold <= 1'b0;
      for (i = 0; i < 2; i++)
      begin
         wr(acsp_pkg::REG_ADDR, 32'h13 - i);
         wr(acsp_pkg::REG_CTRL, {26'h0, i[1:0], 4'h1});
         sts(32'h8);
      end
      xfer({2'b00, 2'h0, acsp_pkg::DEV_IFCFG, 32'h42});
      sts(32'h10);
      xfer({2'b00, 2'h0, 15'h000a, 32'hc3});
      rdev(15'h000a, 32'hc3);
      xfer({2'b00, 2'h0, acsp_pkg::DEV_IFCFG, 32'h81});
      rd(acsp_pkg::REG_STATUS, q);
      chk("recovering", 32'h5, q & 32'h7);
      wr(acsp_pkg::REG_CTRL, 32'h3);
      poll(acsp_pkg::STS_BUSY, 1'b0);
      chk("early", 32'h0, {31'h0, early});
      sts(32'h8);
      rdev(acsp_pkg::DEV_IFCFG, 32'h0);
      rdev(15'h000a, 32'h0);
      rdev(acsp_pkg::DEV_OUTFMT, 32'h1);
      wr(acsp_pkg::REG_DIV, 32'h0c);
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(acsp_pkg::REG_DIV, q);
      chk("div", {24'h0, acsp_pkg::DIV_RESET}, q);
      give_verdict();
   end
endmodule
